// ==== hw/power_cfg_defines.svh ====
`ifndef POWER_CFG_DEFINES_SVH
`define POWER_CFG_DEFINES_SVH

// Register byte addresses.
`define OFS_POWER_DOWN_CONFIG       32'h4000_0210
`define OFS_POWER_DOWN_CONFIG_SET   32'h4000_0214
`define OFS_POWER_DOWN_CONFIG_CLEAR 32'h4000_0218
`define OFS_WAKEUP_SOURCE_LOW       32'h4000_0240

// Implemented bits and reset values.
`define POWER_MASK                  32'h01DB_E5B8
`define POWER_RESET                 32'h00D8_0500
`define WAKE_MASK                   32'h0001_FFFB
`define WAKE_RESET                  32'h0000_0000

// Power control bit positions.
`define BIT_RC_OSC_OUTPUT_OFF       3
`define BIT_RC_OSC_CORE_OFF         4
`define BIT_FLASH_OFF               5
`define BIT_BROWNOUT_RESET_OFF      7
`define BIT_BROWNOUT_IRQ_OFF        8
`define BIT_CONVERTER_OFF           10
`define BIT_RAM_BANK0_LOW_OFF       13
`define BIT_RAM_BANK0_HIGH_OFF      14
`define BIT_RAM_BANK1_OFF           15
`define BIT_RAM_BANK2_OFF           16
`define BIT_BOOT_ROM_OFF            17
`define BIT_CONVERTER_SUPPLY_OFF    19
`define BIT_WATCHDOG_OSC_OFF        20
`define BIT_SYSTEM_PLL_OFF          22
`define BIT_CONVERTER_REFERENCE_OFF 23
`define BIT_SLOW_CRYSTAL_OSC_OFF    24

// Bus response codes and fill values.
`define RESP_OKAY                   2'h0
`define RESP_SLVERR                 2'h2
`define DATA_ZERO                   32'h0000_0000

`endif

// ==== hw/power_cfg_pkg.sv ====
package power_cfg_pkg;

	typedef enum logic [1:0] {
		mode_active,
		mode_sleep,
		mode_deep_sleep,
		mode_power_down
	} power_mode_t;

endpackage : power_cfg_pkg

// ==== hw/wake_gate.sv ====
module wake_gate #(
	parameter int WAKE_W = 17
) (
	input  wire logic [WAKE_W-1:0]         irq_level,
	input  wire logic [WAKE_W-1:0]         enable,
	input  wire logic                      pattern_irq,
	input  wire power_cfg_pkg::power_mode_t mode,
	output logic                           wake
);

	logic [WAKE_W-1:0] gated;
	logic              deep;

	genvar i;
	generate
		for (i = 0; i < WAKE_W; i++) begin : g_gate
			assign gated[i] = irq_level[i] & enable[i];
		end
	endgenerate

	// Pattern match needs a running clock, so it only ends plain sleep.
	assign deep = (mode == power_cfg_pkg::mode_deep_sleep) ||
	              (mode == power_cfg_pkg::mode_power_down);
	assign wake = (deep && (|gated)) ||
	              ((mode == power_cfg_pkg::mode_sleep) && pattern_irq);

endmodule : wake_gate

// ==== hw/power_config_wakeup_enable.sv ====
`include "power_cfg_defines.svh"

// Functional notes
// - Power bit zero keeps resource on, one powers it down; bits 3-5 reset zero.
// - Bit 7 brown-out reset resets on; bit 8 brown-out interrupt resets off.
// - Bit 10 powers down the converter; resets to one.
// - Bits 13-16 RAM banks and bit 17 ROM reset to zero.
// - Bit 20 watchdog oscillator and bit 22 PLL reset to one.
// - Bit 24 slow crystal oscillator resets to zero.
// - Set alias write sets implemented bits written one; write-only.
// - Clear alias write clears implemented bits written one; write-only.
// - Wake enable one allows that interrupt to end deep modes; resets zero.
// - Wake bit 0 watchdog, bit 1 brown-out, bit 3 DMA.
// - Wake bit 4 group interrupt, bits 5-8 pin interrupts, not pattern match.
// - Pattern match never wakes from modes deeper than sleep.
// - Wake bit 9 micro tick, 10 multi-rate, 11-15 timers, 16 state timer.
module power_config_wakeup_enable #(
	parameter int WAKE_W = 17
) (
	input  wire logic                       aclk,
	input  wire logic                       aresetn,
	input  wire logic [31:0]                awaddr,
	input  wire logic [2:0]                 awprot,
	input  wire logic                       awvalid,
	output logic                            awready,
	input  wire logic [31:0]                wdata,
	input  wire logic [3:0]                 wstrb,
	input  wire logic                       wvalid,
	output logic                            wready,
	output logic [1:0]                      bresp,
	output logic                            bvalid,
	input  wire logic                       bready,
	input  wire logic [31:0]                araddr,
	input  wire logic [2:0]                 arprot,
	input  wire logic                       arvalid,
	output logic                            arready,
	output logic [31:0]                     rdata,
	output logic [1:0]                      rresp,
	output logic                            rvalid,
	input  wire logic                       rready,
	input  wire logic [WAKE_W-1:0]          wake_irq,
	input  wire logic                       pattern_match_irq,
	input  wire power_cfg_pkg::power_mode_t power_mode,
	output logic                            wake_request,
	output logic [31:0]                     power_down_config,
	output logic                            rc_osc_output_off,
	output logic                            rc_osc_core_off,
	output logic                            flash_off,
	output logic                            brownout_reset_off,
	output logic                            brownout_irq_off,
	output logic                            converter_off,
	output logic                            ram_bank0_low_off,
	output logic                            ram_bank0_high_off,
	output logic                            ram_bank1_off,
	output logic                            ram_bank2_off,
	output logic                            boot_rom_off,
	output logic                            converter_supply_off,
	output logic                            watchdog_osc_off,
	output logic                            system_pll_off,
	output logic                            converter_reference_off,
	output logic                            slow_crystal_osc_off
);

	function automatic logic reg_hit(input logic [31:0] addr, input logic [31:0] ofs);
		reg_hit = (addr[31:2] == ofs[31:2]);
	endfunction : reg_hit

	function automatic logic [31:0] lane_mask(input logic [3:0] strb);
		lane_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
	endfunction : lane_mask

	logic [31:0]       power_q;
	logic [31:0]       wake_en_q;
	logic              awready_q;
	logic              wready_q;
	logic              aw_full_q;
	logic              w_full_q;
	logic [31:0]       aw_addr_q;
	logic [31:0]       w_data_q;
	logic [3:0]        w_strb_q;
	logic              bvalid_q;
	logic [1:0]        bresp_q;
	logic              arready_q;
	logic              rvalid_q;
	logic [31:0]       rdata_q;
	logic [1:0]        rresp_q;
	logic [WAKE_W-1:0] irq_meta_q;
	logic [WAKE_W-1:0] irq_sync_q;
	logic              pattern_meta_q;
	logic              pattern_sync_q;
	logic              wake_request_q;
	logic              aw_fire;
	logic              w_fire;
	logic              ar_fire;
	logic              wr_go;
	logic              aw_full_d;
	logic              w_full_d;
	logic              bvalid_d;
	logic              rvalid_d;
	logic [31:0]       wr_bits;
	logic              hit_cfg;
	logic              hit_set;
	logic              hit_clr;
	logic              hit_wake;
	logic              wake_d;

	assign aw_fire   = awvalid && awready_q;
	assign w_fire    = wvalid && wready_q;
	assign ar_fire   = arvalid && arready_q;
	// Address and data are parked separately, so they may arrive in either order.
	assign wr_go     = aw_full_q && w_full_q && !bvalid_q;
	assign aw_full_d = aw_full_q ? !wr_go : aw_fire;
	assign w_full_d  = w_full_q ? !wr_go : w_fire;
	assign bvalid_d  = bvalid_q ? !bready : wr_go;
	assign rvalid_d  = rvalid_q ? !rready : ar_fire;
	assign wr_bits   = w_data_q & lane_mask(w_strb_q);
	assign hit_cfg   = reg_hit(aw_addr_q, `OFS_POWER_DOWN_CONFIG);
	assign hit_set   = reg_hit(aw_addr_q, `OFS_POWER_DOWN_CONFIG_SET);
	assign hit_clr   = reg_hit(aw_addr_q, `OFS_POWER_DOWN_CONFIG_CLEAR);
	assign hit_wake  = reg_hit(aw_addr_q, `OFS_WAKEUP_SOURCE_LOW);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_q <= 1'b0;
			w_full_q  <= 1'b0;
			awready_q <= 1'b0;
			wready_q  <= 1'b0;
			aw_addr_q <= `DATA_ZERO;
			w_data_q  <= `DATA_ZERO;
			w_strb_q  <= 4'h0;
		end else begin
			aw_full_q <= aw_full_d;
			w_full_q  <= w_full_d;
			awready_q <= !aw_full_d && !bvalid_d;
			wready_q  <= !w_full_d && !bvalid_d;
			if (aw_fire) begin
				aw_addr_q <= awaddr;
			end
			if (w_fire) begin
				w_data_q <= wdata;
				w_strb_q <= wstrb;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_q <= 1'b0;
			bresp_q  <= `RESP_OKAY;
		end else begin
			bvalid_q <= bvalid_d;
			if (wr_go) begin
				bresp_q <= (hit_cfg || hit_set || hit_clr || hit_wake) ? `RESP_OKAY : `RESP_SLVERR;
			end
		end
	end

	// Only implemented bits can ever be stored, so reserved bits read zero.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			power_q <= `POWER_RESET;
		end else if (wr_go && hit_cfg) begin
			power_q <= ((power_q & ~lane_mask(w_strb_q)) | wr_bits) & `POWER_MASK;
		end else if (wr_go && hit_set) begin
			power_q <= power_q | (wr_bits & `POWER_MASK);
		end else if (wr_go && hit_clr) begin
			power_q <= power_q & ~(wr_bits & `POWER_MASK);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wake_en_q <= `WAKE_RESET;
		end else if (wr_go && hit_wake) begin
			wake_en_q <= ((wake_en_q & ~lane_mask(w_strb_q)) | wr_bits) & `WAKE_MASK;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_q <= 1'b0;
			rvalid_q  <= 1'b0;
			rdata_q   <= `DATA_ZERO;
			rresp_q   <= `RESP_OKAY;
		end else begin
			arready_q <= !rvalid_d;
			rvalid_q  <= rvalid_d;
			if (ar_fire) begin
				rresp_q <= `RESP_OKAY;
				if (reg_hit(araddr, `OFS_POWER_DOWN_CONFIG)) begin
					rdata_q <= power_q;
				end else if (reg_hit(araddr, `OFS_WAKEUP_SOURCE_LOW)) begin
					rdata_q <= wake_en_q;
				end else if (reg_hit(araddr, `OFS_POWER_DOWN_CONFIG_SET) ||
				             reg_hit(araddr, `OFS_POWER_DOWN_CONFIG_CLEAR)) begin
					rdata_q <= `DATA_ZERO;
				end else begin
					rdata_q <= `DATA_ZERO;
					rresp_q <= `RESP_SLVERR;
				end
			end
		end
	end

	// Interrupt lines come from other blocks that may be clocked differently.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_meta_q     <= '0;
			irq_sync_q     <= '0;
			pattern_meta_q <= 1'b0;
			pattern_sync_q <= 1'b0;
		end else begin
			irq_meta_q     <= wake_irq;
			irq_sync_q     <= irq_meta_q;
			pattern_meta_q <= pattern_match_irq;
			pattern_sync_q <= pattern_meta_q;
		end
	end

	wake_gate #(
		.WAKE_W      (WAKE_W)
	) u_wake_gate (
		.irq_level   (irq_sync_q),
		.enable      (wake_en_q[WAKE_W-1:0]),
		.pattern_irq (pattern_sync_q),
		.mode        (power_mode),
		.wake        (wake_d)
	);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wake_request_q <= 1'b0;
		end else begin
			wake_request_q <= wake_d;
		end
	end

	assign awready                 = awready_q;
	assign wready                  = wready_q;
	assign bvalid                  = bvalid_q;
	assign bresp                   = bresp_q;
	assign arready                 = arready_q;
	assign rvalid                  = rvalid_q;
	assign rdata                   = rdata_q;
	assign rresp                   = rresp_q;
	assign wake_request            = wake_request_q;
	assign power_down_config       = power_q;
	assign rc_osc_output_off       = power_q[`BIT_RC_OSC_OUTPUT_OFF];
	assign rc_osc_core_off         = power_q[`BIT_RC_OSC_CORE_OFF];
	assign flash_off               = power_q[`BIT_FLASH_OFF];
	assign brownout_reset_off      = power_q[`BIT_BROWNOUT_RESET_OFF];
	assign brownout_irq_off        = power_q[`BIT_BROWNOUT_IRQ_OFF];
	assign converter_off           = power_q[`BIT_CONVERTER_OFF];
	assign ram_bank0_low_off       = power_q[`BIT_RAM_BANK0_LOW_OFF];
	assign ram_bank0_high_off      = power_q[`BIT_RAM_BANK0_HIGH_OFF];
	assign ram_bank1_off           = power_q[`BIT_RAM_BANK1_OFF];
	assign ram_bank2_off           = power_q[`BIT_RAM_BANK2_OFF];
	assign boot_rom_off            = power_q[`BIT_BOOT_ROM_OFF];
	assign converter_supply_off    = power_q[`BIT_CONVERTER_SUPPLY_OFF];
	assign watchdog_osc_off        = power_q[`BIT_WATCHDOG_OSC_OFF];
	assign system_pll_off          = power_q[`BIT_SYSTEM_PLL_OFF];
	assign converter_reference_off = power_q[`BIT_CONVERTER_REFERENCE_OFF];
	assign slow_crystal_osc_off    = power_q[`BIT_SLOW_CRYSTAL_OSC_OFF];

	default clocking cb @(posedge aclk);
	endclocking

	default disable iff (!aresetn);

	sequence s_set_write;
		wr_go && hit_set;
	endsequence

	sequence s_clear_write;
		wr_go && hit_clr;
	endsequence

	sequence s_both_parked;
		aw_full_q && w_full_q && !bvalid_q;
	endsequence

	sequence s_read_power;
		arvalid && arready_q && reg_hit(araddr, `OFS_POWER_DOWN_CONFIG);
	endsequence

	a_power_reset_value: assert property (
		$rose(aresetn) |-> power_q == `POWER_RESET)
		else $error("Power control register has the wrong reset value.");

	a_wake_reset_value: assert property (
		$rose(aresetn) |-> wake_en_q == `WAKE_RESET)
		else $error("Wake enable register does not reset to zero.");

	a_reserved_bits_zero: assert property (
		((power_q & ~`POWER_MASK) == `DATA_ZERO) && ((wake_en_q & ~`WAKE_MASK) == `DATA_ZERO))
		else $error("A reserved bit holds a one.");

	a_set_alias_effect: assert property (
		s_set_write |=> power_q == ($past(power_q) | ($past(wr_bits) & `POWER_MASK)))
		else $error("Set alias write did not set the written bits.");

	a_clear_alias_effect: assert property (
		s_clear_write |=> power_q == ($past(power_q) & ~($past(wr_bits) & `POWER_MASK)))
		else $error("Clear alias write did not clear the written bits.");

	a_wake_full_write: assert property (
		(wr_go && hit_wake && w_strb_q == 4'hF) |=> wake_en_q == ($past(w_data_q) & `WAKE_MASK))
		else $error("Wake enable write did not update all bits.");

	a_power_readback: assert property (
		s_read_power |=> rvalid_q && rdata_q == $past(power_q) && rresp_q == `RESP_OKAY)
		else $error("Power control read returned a wrong value.");

	a_write_response: assert property (
		s_both_parked |=> bvalid_q ##1 (bvalid_q || $past(bready)))
		else $error("Write response missing or dropped early.");

	a_wake_blocked: assert property (
		(power_mode != power_cfg_pkg::mode_sleep && (irq_sync_q & wake_en_q[WAKE_W-1:0]) == '0)
		|=> !wake_request_q)
		else $error("Wake request without an enabled interrupt.");

	a_pattern_sleep_only: assert property (
		(power_mode == power_cfg_pkg::mode_sleep && pattern_sync_q) |=> wake_request_q)
		else $error("Pattern match did not wake from sleep.");

	a_alias_read_zero: assert property (
		(ar_fire && (reg_hit(araddr, `OFS_POWER_DOWN_CONFIG_SET) ||
		             reg_hit(araddr, `OFS_POWER_DOWN_CONFIG_CLEAR)))
		|=> rdata_q == `DATA_ZERO && rresp_q == `RESP_OKAY)
		else $error("Alias read did not return zero.");

	a_power_hold: assert property (
		!(wr_go && (hit_cfg || hit_set || hit_clr)) |=> $stable(power_q))
		else $error("Power control bits changed without a write.");

	a_wake_hold: assert property (
		!(wr_go && hit_wake) |=> $stable(wake_en_q))
		else $error("Wake enable bits changed without a write.");

endmodule : power_config_wakeup_enable

// ==== verification/power_config_wakeup_enable_tb.sv ====
`include "power_cfg_defines.svh"

module power_config_wakeup_enable_tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic                        aclk;
	logic                        aresetn;
	logic [31:0]                 awaddr;
	logic [31:0]                 wdata;
	logic [31:0]                 araddr;
	logic [3:0]                  wstrb;
	logic                        awvalid;
	logic                        wvalid;
	logic                        bready;
	logic                        arvalid;
	logic                        rready;
	logic                        pattern_match_irq;
	logic [16:0]                 wake_irq;
	power_cfg_pkg::power_mode_t  power_mode;
	logic                        awready;
	logic                        wready;
	logic                        bvalid;
	logic                        arready;
	logic                        rvalid;
	logic                        wake_request;
	logic [1:0]                  bresp;
	logic [1:0]                  rresp;
	logic [31:0]                 rdata;
	logic [31:0]                 power_down_config;
	wire  [15:0]                 pins;
	int                          errors;
	int                          compares;

	power_config_wakeup_enable u_dut (
		.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .wake_irq(wake_irq), .pattern_match_irq(pattern_match_irq),
		.power_mode(power_mode), .wake_request(wake_request),
		.power_down_config(power_down_config), .rc_osc_output_off(pins[0]),
		.rc_osc_core_off(pins[1]), .flash_off(pins[2]), .brownout_reset_off(pins[3]),
		.brownout_irq_off(pins[4]), .converter_off(pins[5]), .ram_bank0_low_off(pins[6]),
		.ram_bank0_high_off(pins[7]), .ram_bank1_off(pins[8]), .ram_bank2_off(pins[9]),
		.boot_rom_off(pins[10]), .converter_supply_off(pins[11]), .watchdog_osc_off(pins[12]),
		.system_pll_off(pins[13]), .converter_reference_off(pins[14]),
		.slow_crystal_osc_off(pins[15])
	);

	initial begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end

	task automatic end_sim;
		$display("errors=%0d compares=%0d", errors, compares);
		if (errors == 0 && compares > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : end_sim

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// The master waits for each channel's own ready; only the watchdog ends a hang.
	task automatic axi_write(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [1:0] er);
		logic aw_done;
		logic w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		@(posedge aclk);
		awaddr  <= a;
		wdata   <= d;
		wstrb   <= s;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		while (!(aw_done && w_done)) begin
			@(posedge aclk);
			if (!aw_done && awready === 1'b1) begin
				awvalid <= 1'b0;
				aw_done = 1'b1;
			end
			if (!w_done && wready === 1'b1) begin
				wvalid <= 1'b0;
				w_done = 1'b1;
			end
		end
		while (bvalid !== 1'b1) @(posedge aclk);
		bready <= 1'b0;
		check({30'h0, bresp}, {30'h0, er});
	endtask : axi_write

	task automatic axi_read(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
		@(posedge aclk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		while (rvalid !== 1'b1) @(posedge aclk);
		rready <= 1'b0;
		check(rdata, ed);
		check({30'h0, rresp}, {30'h0, er});
	endtask : axi_read

	task automatic check_power(input logic [31:0] exp);
		logic [15:0] pin_exp;
		pin_exp = {exp[24:22], exp[20:19], exp[17:13], exp[10], exp[8:7], exp[5:3]};
		axi_read(`OFS_POWER_DOWN_CONFIG, exp, 2'h0);
		check(power_down_config, exp);
		check({16'h0000, pins}, {16'h0000, pin_exp});
	endtask : check_power

	// Three edges cover the two sync stages and the registered request.
	task automatic wake_case(input power_cfg_pkg::power_mode_t m, input logic [16:0] irq,
		input logic pat, input logic exp);
		@(posedge aclk);
		power_mode        <= m;
		wake_irq          <= irq;
		pattern_match_irq <= pat;
		repeat (3) @(posedge aclk);
		#1;
		check({31'h0, wake_request}, {31'h0, exp});
	endtask : wake_case

	task automatic t_reset;
		check_power(32'h00D8_0500);
		axi_read(`OFS_WAKEUP_SOURCE_LOW, 32'h0000_0000, 2'h0);
	endtask : t_reset

	// Software only ever writes defined power bits, as the aliases require.
	task automatic t_alias;
		axi_write(`OFS_POWER_DOWN_CONFIG_SET, 32'h0100_00B8, 4'hF, 2'h0);
		check_power(32'h01D8_05B8);
		axi_write(`OFS_POWER_DOWN_CONFIG_SET, 32'h01DB_E5B8, 4'hF, 2'h0);
		check_power(32'h01DB_E5B8);
		axi_read(`OFS_POWER_DOWN_CONFIG_SET, 32'h0000_0000, 2'h0);
		axi_write(`OFS_POWER_DOWN_CONFIG_CLEAR, 32'h0000_0400, 4'hF, 2'h0);
		check_power(32'h01DB_E1B8);
		axi_write(`OFS_POWER_DOWN_CONFIG_CLEAR, 32'h0000_01B8, 4'h1, 2'h0);
		check_power(32'h01DB_E100);
		axi_read(`OFS_POWER_DOWN_CONFIG_CLEAR, 32'h0000_0000, 2'h0);
		axi_write(`OFS_POWER_DOWN_CONFIG_CLEAR, 32'h0088_0000, 4'hF, 2'h0);
		check_power(32'h0153_E100);
		axi_write(`OFS_POWER_DOWN_CONFIG, 32'h0000_0000, 4'h2, 2'h0);
		check_power(32'h0153_0000);
		axi_write(`OFS_POWER_DOWN_CONFIG, 32'h01DB_E5B8, 4'hF, 2'h0);
		check_power(32'h01DB_E5B8);
	endtask : t_alias

	task automatic t_wake_reg;
		axi_write(`OFS_WAKEUP_SOURCE_LOW, 32'h0001_FFFB, 4'hF, 2'h0);
		axi_read(`OFS_WAKEUP_SOURCE_LOW, 32'h0001_FFFB, 2'h0);
		axi_write(`OFS_WAKEUP_SOURCE_LOW, 32'h0000_0000, 4'h1, 2'h0);
		axi_read(`OFS_WAKEUP_SOURCE_LOW, 32'h0001_FF00, 2'h0);
	endtask : t_wake_reg

	task automatic t_unmapped;
		axi_write(32'h4000_0220, 32'h0000_0000, 4'hF, 2'h2);
		axi_read(32'h4000_0220, 32'h0000_0000, 2'h2);
		check_power(32'h01DB_E5B8);
	endtask : t_unmapped

	// Each enable is tried alone so a swapped bit pairing cannot hide.
	task automatic t_wake;
		for (int i = 0; i < 17; i++) begin
			if (i != 2) begin
				axi_write(`OFS_WAKEUP_SOURCE_LOW, 32'h0000_0001 << i, 4'hF, 2'h0);
				wake_case(power_cfg_pkg::mode_deep_sleep, ~(17'h0_0001 << i), 1'b0, 1'b0);
				wake_case(power_cfg_pkg::mode_power_down, 17'h0_0001 << i, 1'b0, 1'b1);
			end
		end
		axi_write(`OFS_WAKEUP_SOURCE_LOW, 32'h0001_FFFB, 4'hF, 2'h0);
		wake_case(power_cfg_pkg::mode_deep_sleep, 17'h0_0004, 1'b0, 1'b0);
		wake_case(power_cfg_pkg::mode_active, 17'h1_FFFF, 1'b1, 1'b0);
		wake_case(power_cfg_pkg::mode_sleep, 17'h1_FFFF, 1'b0, 1'b0);
		wake_case(power_cfg_pkg::mode_sleep, 17'h0_0000, 1'b1, 1'b1);
		wake_case(power_cfg_pkg::mode_deep_sleep, 17'h0_0000, 1'b1, 1'b0);
		wake_case(power_cfg_pkg::mode_power_down, 17'h0_0000, 1'b1, 1'b0);
	endtask : t_wake

	// Reset after writes have moved the bits, so the reset values must really be reapplied.
	task automatic t_mid_reset;
		@(posedge aclk);
		aresetn  <= 1'b0;
		wake_irq <= 17'h1_FFFF;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		check_power(32'h00D8_0500);
		axi_read(`OFS_WAKEUP_SOURCE_LOW, 32'h0000_0000, 2'h0);
		check({31'h0, wake_request}, 32'h0000_0000);
	endtask : t_mid_reset

	initial begin
		errors = 0;
		compares = 0;
		aresetn = 1'b0;
		awaddr = 32'h0000_0000;
		wdata = 32'h0000_0000;
		araddr = 32'h0000_0000;
		wstrb = 4'h0;
		{awvalid, wvalid, bready, arvalid, rready, pattern_match_irq} = 6'h00;
		wake_irq = 17'h0_0000;
		power_mode = power_cfg_pkg::mode_active;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_reset();
		t_alias();
		t_wake_reg();
		t_unmapped();
		t_wake();
		t_mid_reset();
		end_sim();
	end

	// The sequence needs well under a thousand cycles; this span leaves a wide margin.
	initial begin
		repeat (6000) @(posedge aclk);
		errors++;
		end_sim();
	end

endmodule : power_config_wakeup_enable_tb
